// *** rtl/upr_pkg.sv ***
/*
  upr_pkg: register offsets, field positions, reset values and encodings for the
  usb port router with its two-state power handling.
  assumes: one clock (aclk, 10 MHz) and an axi4-lite register bus with 8-bit addresses.
*/
package upr_pkg;

  // clock figure, kept for any derived timing
  localparam int UPR_CLK_PERIOD_NS = 100;

  // register byte offsets
  localparam logic [7:0] UPR_OFF_CONFIG  = 8'h00; // configure flag, debug route, soft reset
  localparam logic [7:0] UPR_OFF_POWER   = 8'h04; // device power state field
  localparam logic [7:0] UPR_OFF_OWNER   = 8'h08; // per-port owner bits
  localparam logic [7:0] UPR_OFF_STATUS  = 8'h0c; // attach and speed view, read only
  localparam logic [7:0] UPR_OFF_PORT_EN = 8'h10; // enhanced port enable bits, read only
  localparam logic [7:0] UPR_OFF_OC      = 8'h14; // overcurrent sticky bits, write 1 clears
  localparam logic [7:0] UPR_OFF_MMIO    = 8'h40; // controller memory range (debug data word)

  // decoded register select codes
  localparam logic [2:0] UPR_SEL_NONE    = 3'h0;
  localparam logic [2:0] UPR_SEL_CONFIG  = 3'h1;
  localparam logic [2:0] UPR_SEL_POWER   = 3'h2;
  localparam logic [2:0] UPR_SEL_OWNER   = 3'h3;
  localparam logic [2:0] UPR_SEL_STATUS  = 3'h4;
  localparam logic [2:0] UPR_SEL_PORT_EN = 3'h5;
  localparam logic [2:0] UPR_SEL_OC      = 3'h6;
  localparam logic [2:0] UPR_SEL_MMIO    = 3'h7;

  // config register fields
  localparam int UPR_CFG_FLAG_BIT  = 0; // enhanced driver present
  localparam int UPR_CFG_DEBUG_BIT = 1; // debug traffic on the first port
  localparam int UPR_CFG_SRST_BIT  = 2; // controller soft reset, write 1, reads 0

  // power state encodings
  localparam logic [1:0] UPR_PS_ON  = 2'b00; // full-on
  localparam logic [1:0] UPR_PS_OFF = 2'b11; // off

  // reset values
  localparam logic       UPR_CFG_FLAG_RST = 1'b0;
  localparam logic [7:0] UPR_OWNER_RST    = 8'hff;

  // axi response codes
  localparam logic [1:0] UPR_RESP_OKAY   = 2'b00;
  localparam logic [1:0] UPR_RESP_SLVERR = 2'b10;
  localparam logic [1:0] UPR_RESP_DECERR = 2'b11;

endpackage

// *** rtl/upr_port_router.sv ***
/*
  upr_port_router: shares the usb ports between one enhanced controller and the
  classic controllers, two ports per classic controller, and holds the enhanced
  controller's two-state power handling behind an axi4-lite slave.
  assumes: aresetn is the suspend-well reset, core_rst_n the core-well reset; all
  inputs synchronous to aclk; the controllers sit outside and see only these ports.
*/
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

// How it works
// - only full-on and off power states exist
// - off state aborts controller memory accesses
// - debug port works only when full-on
// - off state keeps interrupt low, wake line instead
// - off to full-on write resets controller
// - other power encodings ignored, write completes
// - deep sleep stops pll, resets core well
// - ports pair two per classic controller
// - classic owns without driver or high speed
// - only owner drives and hears the port
// - router alone makes per-controller connect indications
// - overcurrent goes to both, each records it
// - routing state lives in suspend well
// - debug mode gives first port to enhanced
// - slow device leaves enable clear, owner hands over
// - high speed device keeps enhanced, enable set
// - flag clear keeps attach with classic only; debug mode when full-on still takes port 0
// - detach from classic port returns it to enhanced
// - suspend or soft reset clears flag, sets owners
module upr_port_router
  import upr_pkg::*;
#(
  parameter int NPORT = 8                   // ports, two per classic controller
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,         // suspend-well reset
  input  wire logic             core_rst_n,      // core-well reset
  input  wire logic             sleep_deep,      // system in a deep sleep state
  // axi4-lite slave
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // physical port side
  input  wire logic [NPORT-1:0] phy_attach,      // real attach state
  input  wire logic [NPORT-1:0] phy_hs_capable,  // attached device can signal high speed
  input  wire logic [NPORT-1:0] phy_rx_dp,
  input  wire logic [NPORT-1:0] phy_rx_dm,
  output logic [NPORT-1:0]      phy_tx_dp,
  output logic [NPORT-1:0]      phy_tx_dm,
  output logic [NPORT-1:0]      phy_tx_oe_n,     // low while the pair is driven
  input  wire logic [NPORT-1:0] overcurrent_in_n,
  // enhanced controller side
  input  wire logic [NPORT-1:0] enh_tx_dp,
  input  wire logic [NPORT-1:0] enh_tx_dm,
  input  wire logic [NPORT-1:0] enh_tx_drive,
  input  wire logic [NPORT-1:0] enh_port_reset_done, // pulse: port reset finished
  input  wire logic             enh_irq_req,
  output logic [NPORT-1:0]      enh_rx_dp,
  output logic [NPORT-1:0]      enh_rx_dm,
  output logic [NPORT-1:0]      enh_connect,
  output logic [NPORT-1:0]      enh_overcurrent_n,
  output logic [NPORT-1:0]      enh_port_enable,
  output logic                  enh_irq,
  output logic                  wake_event_n,
  output logic                  enh_core_reset,  // internal reset of enhanced controller
  output logic                  pll_enable,
  output logic                  debug_active,
  // classic controller side, ports 2k and 2k+1 belong to controller k
  input  wire logic [NPORT-1:0] cls_tx_dp,
  input  wire logic [NPORT-1:0] cls_tx_dm,
  input  wire logic [NPORT-1:0] cls_tx_drive,
  output logic [NPORT-1:0]      cls_rx_dp,
  output logic [NPORT-1:0]      cls_rx_dm,
  output logic [NPORT-1:0]      cls_connect,
  output logic [NPORT-1:0]      cls_overcurrent_n,
  output logic [NPORT/2-1:0]    cls_ctl_active   // some port of the pair connected
);

  // address decode, shared by the write and read paths
  function automatic logic [2:0] upr_decode(input logic [7:0] addr);
    case (addr)
      UPR_OFF_CONFIG:  upr_decode = UPR_SEL_CONFIG;
      UPR_OFF_POWER:   upr_decode = UPR_SEL_POWER;
      UPR_OFF_OWNER:   upr_decode = UPR_SEL_OWNER;
      UPR_OFF_STATUS:  upr_decode = UPR_SEL_STATUS;
      UPR_OFF_PORT_EN: upr_decode = UPR_SEL_PORT_EN;
      UPR_OFF_OC:      upr_decode = UPR_SEL_OC;
      UPR_OFF_MMIO:    upr_decode = UPR_SEL_MMIO;
      default:         upr_decode = UPR_SEL_NONE;
    endcase
  endfunction

  // byte-lane merge for write strobes
  function automatic logic [31:0] upr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b]) m[8*b +: 8] = new_v[8*b +: 8];
    upr_merge = m;
  endfunction

  // suspend-well state
  logic             cfg_flag;      // enhanced driver present
  logic             debug_route;   // debug traffic on port 0
  logic [NPORT-1:0] owner;         // 1 = classic owns
  logic [NPORT-1:0] sel_cls;       // registered route select
  logic [NPORT-1:0] attach_prev;   // attach one cycle ago
  // core-well state
  logic [1:0]       pwr_state;     // device power state field
  logic [NPORT-1:0] port_en;       // enhanced port enable
  logic [NPORT-1:0] oc_sticky;     // enhanced overcurrent record
  logic [31:0]      debug_word;    // debug data in the controller memory range

  // bus strobes
  logic       wr_fire;             // write address and data taken
  logic       rd_fire;             // read address taken
  logic [2:0] wsel;                // decoded write target
  logic [2:0] rsel;                // decoded read target
  logic       pwr_on;              // full-on state
  logic       wake_reset;          // write that turns off into full-on
  logic       core_clr;            // any core-well reset
  logic       soft_reset;          // controller soft reset written

  assign wr_fire    = awready & awvalid & wvalid;
  assign rd_fire    = arready & arvalid;
  assign wsel       = upr_decode(awaddr);
  assign rsel       = upr_decode(araddr);
  assign pwr_on     = (pwr_state == UPR_PS_ON);
  // off to full-on write generates the internal reset
  assign wake_reset = wr_fire & (wsel == UPR_SEL_POWER) & wstrb[0] &
                      (pwr_state == UPR_PS_OFF) & (wdata[1:0] == UPR_PS_ON);
  // core well cleared by its reset, deep sleep or the wake reset
  assign core_clr   = ~core_rst_n | sleep_deep | wake_reset;
  assign soft_reset = wr_fire & (wsel == UPR_SEL_CONFIG) & wstrb[0] & wdata[UPR_CFG_SRST_BIT];

  // axi write channel: take address and data together, then respond
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= UPR_RESP_OKAY;
    end
    else
    begin
      awready <= ~awready & ~bvalid & awvalid & wvalid;
      wready  <= ~awready & ~bvalid & awvalid & wvalid;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        if (wsel == UPR_SEL_NONE)
          bresp <= UPR_RESP_SLVERR;            // unmapped
        else if (wsel == UPR_SEL_MMIO && !pwr_on)
          bresp <= UPR_RESP_DECERR;            // master abort when off
        else
          bresp <= UPR_RESP_OKAY;              // bad power codes still complete
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // axi read channel: one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= UPR_RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end
    else
    begin
      arready <= ~arready & ~rvalid & arvalid;
      if (rd_fire)
      begin
        rvalid <= 1'b1;
        rresp  <= UPR_RESP_OKAY;
        rdata  <= 32'h0000_0000;
        unique case (rsel)
          UPR_SEL_CONFIG:  rdata[1:0] <= {debug_route, cfg_flag};
          UPR_SEL_POWER:   rdata[1:0] <= pwr_state;
          UPR_SEL_OWNER:   rdata[NPORT-1:0] <= owner;
          UPR_SEL_STATUS:  rdata[2*NPORT-1:0] <= {phy_hs_capable, phy_attach};
          UPR_SEL_PORT_EN: rdata[NPORT-1:0] <= port_en;
          UPR_SEL_OC:      rdata[NPORT-1:0] <= oc_sticky;
          UPR_SEL_MMIO:
          begin
            if (pwr_on)
              rdata <= debug_word;             // debug port live only when on
            else
              rresp <= UPR_RESP_DECERR;        // master abort when off
          end
          UPR_SEL_NONE:    rresp <= UPR_RESP_SLVERR;
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // configure flag and debug route, suspend well only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_flag    <= UPR_CFG_FLAG_RST;         // suspend-well reset
      debug_route <= 1'b0;
    end
    else if (soft_reset)
      cfg_flag    <= UPR_CFG_FLAG_RST;         // soft reset clears the flag
    else if (wr_fire && wsel == UPR_SEL_CONFIG && wstrb[0])
    begin
      cfg_flag    <= wdata[UPR_CFG_FLAG_BIT];
      debug_route <= wdata[UPR_CFG_DEBUG_BIT];
    end
  end

  // owner bits: software write, hardware return on detach
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      owner <= UPR_OWNER_RST;                  // all classic after suspend reset
    else if (soft_reset)
      owner <= UPR_OWNER_RST;                  // same on soft reset
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        // detach from a classic port returns it empty to enhanced
        if (cfg_flag && owner[p] && attach_prev[p] && !phy_attach[p])
          owner[p] <= 1'b0;
        else if (wr_fire && wsel == UPR_SEL_OWNER && wstrb[p/8])
          owner[p] <= wdata[p];                // driver hands slow device over
      end
    end
  end

  // registered route select, no glitch when owner or flag change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_cls     <= {NPORT{1'b1}};
      attach_prev <= '0;
    end
    else
    begin
      attach_prev <= phy_attach;
      for (int p = 0; p < NPORT; p++)
      begin
        if (p == 0 && debug_route && pwr_on)
          sel_cls[p] <= 1'b0;                  // debug forces port 0 to enhanced
        else
          sel_cls[p] <= ~cfg_flag | owner[p];  // no driver or handed over
      end
    end
  end

  // per-port datapath and connect indications
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phy_tx_dp   <= '0;
      phy_tx_dm   <= '0;
      phy_tx_oe_n <= {NPORT{1'b1}};
      enh_rx_dp   <= '0;
      enh_rx_dm   <= '0;
      cls_rx_dp   <= '0;
      cls_rx_dm   <= '0;
      enh_connect <= '0;
      cls_connect <= '0;
    end
    else
    begin
      // only the owner drives the pair
      phy_tx_dp   <= (sel_cls & cls_tx_dp) | (~sel_cls & enh_tx_dp);
      phy_tx_dm   <= (sel_cls & cls_tx_dm) | (~sel_cls & enh_tx_dm);
      phy_tx_oe_n <= ~((sel_cls & cls_tx_drive) | (~sel_cls & enh_tx_drive));
      // non-owner hears an idle, disconnected line
      enh_rx_dp   <= ~sel_cls & phy_rx_dp;
      enh_rx_dm   <= ~sel_cls & phy_rx_dm;
      cls_rx_dp   <= sel_cls & phy_rx_dp;
      cls_rx_dm   <= sel_cls & phy_rx_dm;
      // electrical connect made from the real attach
      enh_connect <= ~sel_cls & phy_attach;
      cls_connect <= sel_cls & phy_attach;
    end
  end

  // classic controller k serves ports 2k and 2k+1
  generate
    for (genvar k = 0; k < NPORT/2; k++)
    begin : g_pair
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cls_ctl_active[k] <= 1'b0;
        else
          cls_ctl_active[k] <= cls_connect[2*k] | cls_connect[2*k+1];
      end
    end
  endgenerate

  // overcurrent to both controllers, enhanced record here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enh_overcurrent_n <= {NPORT{1'b1}};
      cls_overcurrent_n <= {NPORT{1'b1}};
    end
    else
    begin
      enh_overcurrent_n <= overcurrent_in_n;
      cls_overcurrent_n <= overcurrent_in_n;
    end
  end

  // overcurrent sticky bits, a new event beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_clr)
      oc_sticky <= '0;
    else if (wr_fire && wsel == UPR_SEL_OC && wstrb[0])
      oc_sticky <= (oc_sticky & ~wdata[NPORT-1:0]) | ~overcurrent_in_n;
    else
      oc_sticky <= oc_sticky | ~overcurrent_in_n;
  end

  // enhanced port enable after port reset, set only for high speed
  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_clr)
      port_en <= '0;
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (sel_cls[p] || !phy_attach[p])
          port_en[p] <= 1'b0;                  // not ours or empty
        else if (enh_port_reset_done[p])
          port_en[p] <= phy_hs_capable[p];
      end
    end
  end

  // power state: only two codes stored, others leave it as is
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !core_rst_n || sleep_deep)
      pwr_state <= UPR_PS_ON;
    else if (wr_fire && wsel == UPR_SEL_POWER && wstrb[0] &&
             (wdata[1:0] == UPR_PS_ON || wdata[1:0] == UPR_PS_OFF))
      pwr_state <= wdata[1:0];
  end

  // debug data word, writable only while full-on
  always_ff @(posedge aclk)
  begin
    if (!aresetn || core_clr)
      debug_word <= 32'h0000_0000;
    else if (wr_fire && wsel == UPR_SEL_MMIO && pwr_on)
      debug_word <= upr_merge(debug_word, wdata, wstrb);
  end

  // interrupt, wake line, reset and pll outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enh_irq        <= 1'b0;
      wake_event_n   <= 1'b1;
      enh_core_reset <= 1'b1;
      pll_enable     <= 1'b0;
      debug_active   <= 1'b0;
    end
    else
    begin
      enh_irq        <= enh_irq_req & pwr_on;  // never when off
      wake_event_n   <= ~(~pwr_on & (enh_irq_req | |(attach_prev ^ phy_attach)));
      enh_core_reset <= core_clr;
      pll_enable     <= ~sleep_deep;
      debug_active   <= debug_route & pwr_on;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_off_to_on;
    wr_fire && wsel == UPR_SEL_POWER && wstrb[0] && pwr_state == UPR_PS_OFF
      && wdata[1:0] == UPR_PS_ON;
  endsequence
  sequence s_mmio_read_off;
    rd_fire && rsel == UPR_SEL_MMIO && pwr_state != UPR_PS_ON;
  endsequence

  a_irq_quiet_off: assert property (pwr_state == UPR_PS_OFF |=> !enh_irq)
    else $error("interrupt asserted while off");
  a_mmio_abort_off: assert property (s_mmio_read_off |=> rvalid && rresp == UPR_RESP_DECERR)
    else $error("memory read while off not aborted");
  a_wake_core_reset: assert property (s_off_to_on |=> enh_core_reset && pwr_state == UPR_PS_ON)
    else $error("off to on write gave no reset");
  a_bad_code_kept: assert property (
    wr_fire && wsel == UPR_SEL_POWER && (wdata[1:0] == 2'b01 || wdata[1:0] == 2'b10)
    && core_rst_n && !sleep_deep |=> $stable(pwr_state) && bvalid && bresp == UPR_RESP_OKAY)
    else $error("bad power code changed state");
  a_sleep_pll_off: assert property (
    sleep_deep |=> !pll_enable && enh_core_reset && pwr_state == UPR_PS_ON)
    else $error("deep sleep left pll or core well");
  a_debug_port_zero: assert property (debug_route && pwr_on |=> !sel_cls[0] ##1 !cls_connect[0])
    else $error("debug mode left port 0 to classic");
  a_soft_reset_dflt: assert property (soft_reset |=> !cfg_flag && owner == UPR_OWNER_RST)
    else $error("soft reset did not restore routing");
  a_detach_return: assert property (
    cfg_flag && owner[5] && attach_prev[5] && !phy_attach[5] && !soft_reset |=> !owner[5])
    else $error("detach did not return port to enhanced");
  a_flag_clear_cls: assert property (
    !cfg_flag && !(debug_route && pwr_on) |=> sel_cls[0]
    ##1 !enh_connect[0] && enh_rx_dp[0] == 1'b0)
    else $error("attach seen by enhanced with flag clear");
  a_oc_both_ends: assert property (
    !overcurrent_in_n[1] && !core_clr |=> !enh_overcurrent_n[1] && !cls_overcurrent_n[1]
    && oc_sticky[1])
    else $error("overcurrent not passed to both");
  a_slow_enable_clr: assert property (
    enh_port_reset_done[5] && !sel_cls[5] && phy_attach[5] && !core_clr
    |=> port_en[5] == $past(phy_hs_capable[5]))
    else $error("port enable wrong after reset");

  assign enh_port_enable = port_en;

endmodule

// *** verif/upr_far_side.sv ***
/*
  upr_far_side: the classic controllers and the devices on the eight ports.
  assumes: clocked by the bench's aclk; the attach and speed wishes come from the bench.
*/
`timescale 1ns/1ps
module upr_far_side
  import upr_pkg::*;
(
  input  wire logic [7:0] dev_attach,     // attach pattern wanted by the bench
  input  wire logic [7:0] dev_hs,         // speed pattern wanted by the bench
  input  wire logic [7:0] cls_connect,    // what the classic side is shown
  input  wire logic       aclk,
  output logic [7:0]      phy_attach,
  output logic [7:0]      phy_hs_capable,
  output logic [7:0]      phy_rx_dp,
  output logic [7:0]      phy_rx_dm,
  output logic [7:0]      cls_tx_dp,
  output logic [7:0]      cls_tx_dm,
  output logic [7:0]      cls_tx_drive
);
  logic [7:0] tog = 8'h55;                // line pattern, flips every cycle
  // devices: detached lines sit at the host pull-down level
  always @(posedge aclk)
  begin
    tog            <= ~tog;
    phy_attach     <= dev_attach;
    phy_hs_capable <= dev_hs & dev_attach;
    phy_rx_dp      <= dev_attach & tog;
    phy_rx_dm      <= dev_attach & ~tog;
  end
  // classic controllers drive only the ports they are shown as connected
  always @(posedge aclk)
  begin
    cls_tx_drive <= cls_connect;
    cls_tx_dp    <= cls_connect & ~tog;
    cls_tx_dm    <= cls_connect & tog;
  end
endmodule

// *** verif/usb_port_routing_power_states_test.sv ***
/*
  usb_port_routing_power_states_test: self-checking bench for upr_port_router.
  assumes: upr_far_side stands for the classic controllers and devices.
*/
`timescale 1ns/1ps
module usb_port_routing_power_states_test
  import upr_pkg::*;
;
  logic        aclk = 0, aresetn, core_rst_n, sleep_deep, awvalid, wvalid, bready, arvalid;
  logic        rready, enh_irq_req, awready, wready, bvalid, arready, rvalid, enh_irq;
  logic        wake_event_n, enh_core_reset, pll_enable, debug_active;
  logic [7:0]  awaddr, araddr, phy_attach, phy_hs_capable, phy_rx_dp, phy_rx_dm, phy_tx_dp;
  logic [7:0]  phy_tx_dm, phy_tx_oe_n, overcurrent_in_n, enh_tx_dp, enh_tx_dm, enh_tx_drive;
  logic [7:0]  enh_port_reset_done, enh_rx_dp, enh_rx_dm, enh_connect, enh_overcurrent_n;
  logic [7:0]  enh_port_enable, cls_tx_dp, cls_tx_dm, cls_tx_drive, cls_rx_dp, cls_rx_dm;
  logic [7:0]  cls_connect, cls_overcurrent_n, dev_attach, dev_hs, att;
  logic [3:0]  wstrb, cls_ctl_active;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] wdata, rdata, d, v, seed = 32'h38;
  int          n_fail = 0, num_checks = 0, rst_cnt = 0, k;

  // 100 ns clock
  always #50 aclk = ~aclk;
  // counts cycles of the controller's internal reset
  always @(posedge aclk)
    if (enh_core_reset === 1'b1) rst_cnt <= rst_cnt + 1;

  upr_port_router DUT (.aclk, .aresetn, .core_rst_n, .sleep_deep, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .phy_attach, .phy_hs_capable, .phy_rx_dp, .phy_rx_dm,
    .phy_tx_dp, .phy_tx_dm, .phy_tx_oe_n, .overcurrent_in_n, .enh_tx_dp, .enh_tx_dm,
    .enh_tx_drive, .enh_port_reset_done, .enh_irq_req, .enh_rx_dp, .enh_rx_dm, .enh_connect,
    .enh_overcurrent_n, .enh_port_enable, .enh_irq, .wake_event_n, .enh_core_reset,
    .pll_enable, .debug_active, .cls_tx_dp, .cls_tx_dm, .cls_tx_drive, .cls_rx_dp, .cls_rx_dm,
    .cls_connect, .cls_overcurrent_n, .cls_ctl_active);
  upr_far_side far (.dev_attach, .dev_hs, .cls_connect, .aclk, .phy_attach, .phy_hs_capable,
    .phy_rx_dp, .phy_rx_dm, .cls_tx_dp, .cls_tx_dm, .cls_tx_drive);

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected classic ownership per port
  function automatic logic [7:0] exp_cls(input logic f, input logic [7:0] o, input logic g);
    logic [7:0] s;
    s = ~{8{f}} | o;
    if (g) s[0] = 1'b0;
    return s;
  endfunction
  // verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait gave up
  task automatic hang();
    n_fail++;
    wrap_up();
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dd;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (i == 50) hang();
    rr = bresp;
    bready <= 1'b0;
  endtask
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (i == 50) hang();
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, enh_irq_req, sleep_deep} = '0;
    {awaddr, araddr, wdata, enh_tx_dp, enh_tx_dm, enh_tx_drive, enh_port_reset_done} = '0;
    {dev_attach, dev_hs} = '0;
    core_rst_n = 1'b1;
    wstrb = 4'hf;
    overcurrent_in_n = 8'hff;
    wt(10);
    aresetn <= 1'b1;
    rd(UPR_OFF_OWNER, d, r);
    chk(d, 32'hff);
    rd(UPR_OFF_CONFIG, d, r);
    chk(d, 32'h0);
    att = 8'h35;
    dev_attach <= att;
    dev_hs <= 8'h0f;
    wt(4);
    chk(enh_connect, 8'h00);
    chk(cls_ctl_active, 4'h7);
    d = 32'h0;                                        // expected overcurrent record
    // random owner, flag and debug routing mix
    for (k = 0; k < 24; k++)
    begin
      v = rnd();
      wr(UPR_OFF_OWNER, v[7:0], r);
      wr(UPR_OFF_CONFIG, {30'h0, v[9:8]}, r);
      overcurrent_in_n <= v[23:16];
      d[7:0] = d[7:0] | ~v[23:16];
      enh_tx_dp <= v[31:24];
      enh_tx_dm <= ~v[31:24];
      wt(4);
      chk(cls_connect, att & exp_cls(v[8], v[7:0], v[9]));
      chk(enh_connect, att & ~exp_cls(v[8], v[7:0], v[9]));
      chk(debug_active, v[9]);
      chk({enh_overcurrent_n, cls_overcurrent_n}, {2{v[23:16]}});
    end
    rd(UPR_OFF_OC, v, r);
    chk(v, d);
    // flag set: fast device on port 4, slow one on port 5
    wr(UPR_OFF_CONFIG, 32'h1, r);
    wr(UPR_OFF_OWNER, 32'h0, r);
    dev_attach <= 8'h30;
    dev_hs <= 8'h10;
    wt(4);
    enh_port_reset_done <= 8'h30;
    wt(1);
    enh_port_reset_done <= 8'h00;
    wt(3);
    chk(enh_port_enable & 8'h30, 8'h10);
    chk(cls_connect, 8'h00);
    wr(UPR_OFF_OWNER, 32'h20, r);
    enh_tx_drive <= 8'h10;
    wt(4);
    chk({cls_connect, enh_connect}, 16'h2010);
    chk({cls_rx_dp[4], cls_rx_dm[4], enh_rx_dp[4] ^ enh_rx_dm[4]}, 3'b001);
    chk({phy_tx_oe_n[5:4], phy_tx_dp[4]}, {2'b00, enh_tx_dp[4]});
    chk(phy_tx_dm[4], enh_tx_dm[4]);
    dev_attach <= 8'h10;
    wt(4);
    rd(UPR_OFF_OWNER, d, r);
    chk(d, 32'h0);
    // power states: odd encodings ignored, then off
    for (k = 1; k < 3; k++)
    begin
      wr(UPR_OFF_POWER, k, r);
      chk(r, UPR_RESP_OKAY);
      rd(UPR_OFF_POWER, d, r);
      chk({d[29:0], r}, {30'h0, UPR_RESP_OKAY});
    end
    enh_tx_drive <= 8'h00;                            // ports idle before off
    wr(UPR_OFF_CONFIG, 32'h3, r);
    wr(UPR_OFF_POWER, 32'h3, r);
    rd(UPR_OFF_POWER, d, r);
    chk(d[1:0], UPR_PS_OFF);
    rd(UPR_OFF_MMIO, d, r);
    chk(r, UPR_RESP_DECERR);
    enh_irq_req <= 1'b1;
    wt(4);
    chk({enh_irq, wake_event_n, debug_active}, 3'b000);
    k = rst_cnt;
    wr(UPR_OFF_POWER, 32'h0, r);
    wt(4);
    chk({rst_cnt[3:0] - k[3:0], enh_irq}, 5'h3);
    rd(UPR_OFF_CONFIG, d, r);
    chk(d, 32'h3);
    // core reset and deep sleep keep routing
    core_rst_n <= 1'b0;
    sleep_deep <= 1'b1;
    wt(4);
    chk({pll_enable, enh_core_reset}, 2'b01);
    core_rst_n <= 1'b1;
    sleep_deep <= 1'b0;
    wt(2);
    rd(UPR_OFF_CONFIG, d, r);
    chk(d, 32'h3);
    rd(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, UPR_RESP_SLVERR});
    // soft reset
    wr(UPR_OFF_CONFIG, 32'h4, r);
    rd(UPR_OFF_OWNER, d, r);
    chk(d, 32'hff);
    rd(UPR_OFF_CONFIG, d, r);
    chk(d, 32'h2);
    wrap_up();
  end
endmodule
